// File: verilog/uhps_top.v
`include "uhps_defines.vh"
module uhps_top #(
   parameter NPORTS = 4
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire hub_power_on_reset,
   input wire port_count_strap_a,
   input wire port_count_strap_b_n,
   input wire [NPORTS-1:0] port_overcurrent_sense_n,
   output wire [NPORTS-1:0] port_power_enable_n,
   input wire [NPORTS-1:0] port_data_plus_i,
   input wire [NPORTS-1:0] port_data_minus_i,
   output wire [NPORTS-1:0] port_data_plus_o,
   output wire [NPORTS-1:0] port_data_minus_o,
   output wire [NPORTS-1:0] port_data_plus_oe,
   output wire [NPORTS-1:0] port_data_minus_oe,
   input wire [NPORTS-1:0] core_power_on,
   input wire [NPORTS-1:0] core_tx_dp,
   input wire [NPORTS-1:0] core_tx_dm,
   input wire [NPORTS-1:0] core_tx_oe,
   output wire [NPORTS-1:0] core_rx_dp,
   output wire [NPORTS-1:0] core_rx_dm,
   output wire [NPORTS-1:0] core_overcurrent,
   input wire [NPORTS-1:0] core_conn_change,
   output wire [NPORTS-1:0] core_conn_change_out,
   input wire desc_rd,
   input wire [3:0] desc_idx,
   output wire [7:0] desc_byte,
   output wire desc_valid,
   input wire req_valid,
   input wire [7:0] req_port,
   output reg req_done,
   output reg req_error,
   output wire [NPORTS-1:0] port_active
);
   // ****************************************
   // helpers
   // ****************************************

   // bitmap of present ports, bit 0 reserved
   function [4:0] count_mask;
      input [2:0] cnt;
      begin
         count_mask = 5'h00;
         if (cnt >= 3'd1) count_mask[1] = 1'b1;
         if (cnt >= 3'd2) count_mask[2] = 1'b1;
         if (cnt >= 3'd3) count_mask[3] = 1'b1;
         if (cnt >= 3'd4) count_mask[4] = 1'b1;
      end
   endfunction

   // ****************************************
   // strap capture
   // ****************************************
   reg por_m_r;
   reg por_s_r;
   reg sa_m_r;
   reg sa_s_r;
   reg sb_m_r;
   reg sb_s_r;
   reg [2:0] strap_cnt_r;

   // synchronise reset and strap pins
   always @(posedge aclk) begin
      if (!aresetn) begin
         por_m_r <= 1'b0;
         por_s_r <= 1'b0;
         sa_m_r <= 1'b0;
         sa_s_r <= 1'b0;
         sb_m_r <= 1'b1;
         sb_s_r <= 1'b1;
      end else begin
         por_m_r <= hub_power_on_reset;
         por_s_r <= por_m_r;
         sa_m_r <= port_count_strap_a;
         sa_s_r <= sa_m_r;
         sb_m_r <= port_count_strap_b_n;
         sb_s_r <= sb_m_r;
      end
   end

   // latch strap count during power-on reset
   always @(posedge aclk) begin
      if (!aresetn) begin
         strap_cnt_r <= 3'd4;
      end else if (por_s_r) begin
         strap_cnt_r <= {1'b0, ~sb_s_r, sa_s_r} + 3'd1;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   reg [31:0] ctrl_r;
   reg [31:0] char_r;
   reg [4:0] remove_r;
   reg [4:0] pwrmask_r;
   reg [2:0] sel_cnt;
   reg [7:0] aw_addr_r;
   reg aw_held_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg w_held_r;
   reg [31:0] wmask;
   reg [31:0] rd_nxt;
   reg rd_err;
   wire [4:0] sel_mask;
   wire do_write;

   // selected count, register or strap
   always @* begin
      if (ctrl_r[`UHPS_CTRL_SRC_BIT]) begin
         sel_cnt = {1'b0, ctrl_r[`UHPS_CTRL_CNT_LSB +: 2]} + 3'd1;
      end else begin
         sel_cnt = strap_cnt_r;
      end
   end

   assign sel_mask = count_mask(sel_cnt);
   assign port_active = sel_mask[NPORTS:1];

   // write channel acceptance
   assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
   assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;

   // byte strobe expansion
   always @* begin
      wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   end

   // address and data holding
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // register writes and write response
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `UHPS_CTRL_RST;
         char_r <= `UHPS_CHAR_RST;
         remove_r <= 5'h00;
         pwrmask_r <= 5'h00;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `UHPS_RESP_OKAY;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `UHPS_RESP_OKAY;
            if (aw_addr_r[7:2] == `UHPS_OFS_CTRL >> 2) begin
               ctrl_r <= ((ctrl_r & ~wmask) | (w_data_r & wmask)) & 32'h0000_0007;
            end else if (aw_addr_r[7:2] == `UHPS_OFS_CHAR >> 2) begin
               char_r <= ((char_r & ~wmask) | (w_data_r & wmask)) & 32'h00FF_FF1F;
            end else if (aw_addr_r[7:2] == `UHPS_OFS_REMOVE >> 2) begin
               if (w_strb_r[0]) remove_r <= {w_data_r[4:1], 1'b0};
            end else if (aw_addr_r[7:2] == `UHPS_OFS_PWRMASK >> 2) begin
               if (w_strb_r[0]) pwrmask_r <= {w_data_r[4:1], 1'b0};
            end else if (aw_addr_r[7:2] == `UHPS_OFS_STATUS >> 2) begin
               s_axi_bresp <= `UHPS_RESP_OKAY;
            end else begin
               s_axi_bresp <= `UHPS_RESP_SLVERR;
            end
         end
      end
   end

   // read decode
   always @* begin
      rd_nxt = 32'h0000_0000;
      rd_err = 1'b0;
      if (s_axi_araddr[7:2] == `UHPS_OFS_CTRL >> 2) begin
         rd_nxt = ctrl_r;
      end else if (s_axi_araddr[7:2] == `UHPS_OFS_CHAR >> 2) begin
         rd_nxt = char_r;
      end else if (s_axi_araddr[7:2] == `UHPS_OFS_REMOVE >> 2) begin
         rd_nxt = {27'h0, remove_r};
      end else if (s_axi_araddr[7:2] == `UHPS_OFS_PWRMASK >> 2) begin
         rd_nxt = {27'h0, pwrmask_r};
      end else if (s_axi_araddr[7:2] == `UHPS_OFS_STATUS >> 2) begin
         rd_nxt = {18'h0, strap_cnt_r, 3'h0, sel_mask, sel_cnt};
      end else begin
         rd_err = 1'b1;
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;

   // read response
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `UHPS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_nxt;
         s_axi_rresp <= rd_err ? `UHPS_RESP_SLVERR : `UHPS_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // port request check
   // ****************************************

   // port zero or beyond count is nonexistent
   always @(posedge aclk) begin
      if (!aresetn) begin
         req_done <= 1'b0;
         req_error <= 1'b0;
      end else begin
         req_done <= req_valid;
         if (req_valid) begin
            req_error <= (req_port == 8'h00) || (req_port > {5'h00, sel_cnt});
         end
      end
   end

   // ****************************************
   // descriptor and port gates
   // ****************************************
   uhps_desc_gen u_desc (
      .aclk(aclk),
      .aresetn(aresetn),
      .port_count(sel_cnt),
      .port_mask(sel_mask),
      .char_cfg(char_r),
      .removable_cfg(remove_r),
      .pwrmask_cfg(pwrmask_r),
      .desc_rd(desc_rd),
      .desc_idx(desc_idx),
      .desc_byte(desc_byte),
      .desc_valid(desc_valid)
   );

   // one gate per downstream port; minus enable shares plus enable
   assign port_data_minus_oe = port_data_plus_oe;
   genvar gi;
   generate
      for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_port
         uhps_port_gate u_gate (
            .aclk(aclk),
            .aresetn(aresetn),
            .port_sel(sel_mask[gi+1]),
            .port_overcurrent_sense_n(port_overcurrent_sense_n[gi]),
            .oc_event(core_overcurrent[gi]),
            .power_on(core_power_on[gi]),
            .port_power_enable_n(port_power_enable_n[gi]),
            .tx_dp(core_tx_dp[gi]),
            .tx_dm(core_tx_dm[gi]),
            .tx_oe(core_tx_oe[gi]),
            .port_data_plus_i(port_data_plus_i[gi]),
            .port_data_minus_i(port_data_minus_i[gi]),
            .port_data_plus_o(port_data_plus_o[gi]),
            .port_data_minus_o(port_data_minus_o[gi]),
            .port_data_oe(port_data_plus_oe[gi]),
            .rx_dp(core_rx_dp[gi]),
            .rx_dm(core_rx_dm[gi]),
            .conn_change(core_conn_change[gi]),
            .non_removable(remove_r[gi+1]),
            .conn_change_out(core_conn_change_out[gi])
         );
      end
   endgenerate
endmodule

// File: pkg/uhps_defines.vh
`ifndef UHPS_DEFINES_VH
`define UHPS_DEFINES_VH
// register byte offsets
`define UHPS_OFS_CTRL 8'h00
`define UHPS_OFS_CHAR 8'h04
`define UHPS_OFS_REMOVE 8'h08
`define UHPS_OFS_PWRMASK 8'h0C
`define UHPS_OFS_STATUS 8'h10
// ctrl fields
`define UHPS_CTRL_SRC_BIT 0
`define UHPS_CTRL_CNT_LSB 1
`define UHPS_CTRL_RST 32'h0000_0006
// characteristics register fields
`define UHPS_CHAR_PWRSW_LSB 0
`define UHPS_CHAR_COMPOUND_BIT 2
`define UHPS_CHAR_OC_LSB 3
`define UHPS_CHAR_PGOOD_LSB 8
`define UHPS_CHAR_CURR_LSB 16
`define UHPS_CHAR_RST 32'h0064_3209
// descriptor layout
`define UHPS_DESC_LEN 8'h09
`define UHPS_DESC_TYPE 8'h29
`define UHPS_IDX_LEN 4'h0
`define UHPS_IDX_TYPE 4'h1
`define UHPS_IDX_NBR 4'h2
`define UHPS_IDX_CHAR_LO 4'h3
`define UHPS_IDX_CHAR_HI 4'h4
`define UHPS_IDX_PGOOD 4'h5
`define UHPS_IDX_CURR 4'h6
`define UHPS_IDX_REMOVE 4'h7
`define UHPS_IDX_PWRMASK 4'h8
// power-good unit, microseconds per count
`define UHPS_PGOOD_UNIT_US 2000
// axi responses
`define UHPS_RESP_OKAY 2'h0
`define UHPS_RESP_SLVERR 2'h2
`endif

// File: verilog/uhps_port_gate.v
`include "uhps_defines.vh"
// ****************************************
// one downstream port pin gate
// ****************************************
module uhps_port_gate (
   input wire aclk,
   input wire aresetn,
   input wire port_sel,
   input wire port_overcurrent_sense_n,
   output wire oc_event,
   input wire power_on,
   output reg port_power_enable_n,
   input wire tx_dp,
   input wire tx_dm,
   input wire tx_oe,
   input wire port_data_plus_i,
   input wire port_data_minus_i,
   output reg port_data_plus_o,
   output reg port_data_minus_o,
   output reg port_data_oe,
   output wire rx_dp,
   output wire rx_dm,
   input wire conn_change,
   input wire non_removable,
   output wire conn_change_out
);
   reg oc_m_r;
   reg oc_s_r;
   reg dp_m_r;
   reg dp_s_r;
   reg dm_m_r;
   reg dm_s_r;

   // pin synchronisers
   always @(posedge aclk) begin
      if (!aresetn) begin
         oc_m_r <= 1'b1;
         oc_s_r <= 1'b1;
         dp_m_r <= 1'b0;
         dp_s_r <= 1'b0;
         dm_m_r <= 1'b0;
         dm_s_r <= 1'b0;
      end else begin
         oc_m_r <= port_overcurrent_sense_n;
         oc_s_r <= oc_m_r;
         dp_m_r <= port_data_plus_i;
         dp_s_r <= dp_m_r;
         dm_m_r <= port_data_minus_i;
         dm_s_r <= dm_m_r;
      end
   end

   // sense and receive ignored on an unselected port
   assign oc_event = port_sel & ~oc_s_r;
   assign rx_dp = port_sel & dp_s_r;
   assign rx_dm = port_sel & dm_s_r;
   assign conn_change_out = port_sel & conn_change & ~non_removable;

   // registered pin drivers
   always @(posedge aclk) begin
      if (!aresetn) begin
         port_power_enable_n <= 1'b0;
         port_data_plus_o <= 1'b0;
         port_data_minus_o <= 1'b0;
         port_data_oe <= 1'b0;
      end else begin
         port_power_enable_n <= port_sel ? ~power_on : 1'b0;
         port_data_plus_o <= port_sel & tx_dp;
         port_data_minus_o <= port_sel & tx_dm;
         port_data_oe <= port_sel & tx_oe;
      end
   end
endmodule

// File: verilog/uhps_desc_gen.v
`include "uhps_defines.vh"
// ****************************************
// hub class descriptor byte source
// ****************************************
module uhps_desc_gen (
   input wire aclk,
   input wire aresetn,
   input wire [2:0] port_count,
   input wire [4:0] port_mask,
   input wire [31:0] char_cfg,
   input wire [4:0] removable_cfg,
   input wire [4:0] pwrmask_cfg,
   input wire desc_rd,
   input wire [3:0] desc_idx,
   output reg [7:0] desc_byte,
   output reg desc_valid
);
   reg [7:0] byte_nxt;
   wire [15:0] hub_char;

   // reserved characteristic bits read zero
   assign hub_char = {11'h000, char_cfg[4:0]};

   // byte select
   always @* begin
      byte_nxt = 8'h00;
      case (desc_idx)
         `UHPS_IDX_LEN: byte_nxt = `UHPS_DESC_LEN;
         `UHPS_IDX_TYPE: byte_nxt = `UHPS_DESC_TYPE;
         `UHPS_IDX_NBR: byte_nxt = {5'h00, port_count};
         `UHPS_IDX_CHAR_LO: byte_nxt = hub_char[7:0];
         `UHPS_IDX_CHAR_HI: byte_nxt = hub_char[15:8];
         `UHPS_IDX_PGOOD: byte_nxt = char_cfg[`UHPS_CHAR_PGOOD_LSB +: 8];
         `UHPS_IDX_CURR: byte_nxt = char_cfg[`UHPS_CHAR_CURR_LSB +: 8];
         `UHPS_IDX_REMOVE: byte_nxt = {3'h0, removable_cfg & port_mask};
         `UHPS_IDX_PWRMASK: byte_nxt = {3'h0, pwrmask_cfg & port_mask};
         default: byte_nxt = 8'h00;
      endcase
   end

   // one cycle answer
   always @(posedge aclk) begin
      if (!aresetn) begin
         desc_byte <= 8'h00;
         desc_valid <= 1'b0;
      end else begin
         desc_valid <= desc_rd;
         if (desc_rd) begin
            desc_byte <= byte_nxt;
         end
      end
   end
endmodule

// File: tb/uhps_top_sva.sv
`include "uhps_defines.vh"
module uhps_top_sva #(
   parameter NPORTS = 4
) (
   input wire aclk,
   input wire aresetn,
   input wire [NPORTS-1:0] port_active,
   input wire [NPORTS-1:0] port_power_enable_n,
   input wire [NPORTS-1:0] port_data_plus_oe,
   input wire [NPORTS-1:0] port_data_minus_oe,
   input wire [NPORTS-1:0] core_rx_dp,
   input wire [NPORTS-1:0] core_overcurrent,
   input wire [NPORTS-1:0] core_conn_change_out,
   input wire desc_rd,
   input wire [3:0] desc_idx,
   input wire [7:0] desc_byte,
   input wire desc_valid,
   input wire req_valid,
   input wire [7:0] req_port,
   input wire req_done,
   input wire req_error
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [7:0] cnt_r;
   reg [7:0] port_r;
   reg [NPORTS-1:0] act_r;
   // selected count, request port and selection one cycle back
   always @(posedge aclk) begin
      cnt_r <= 8'($countones(port_active));
      port_r <= req_port;
      act_r <= port_active;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_unsel_pwr_low: assert property ((~port_active & ~act_r & port_power_enable_n) == '0)
      else $error("power enable not low on unselected port");
   a_unsel_data_off: assert property ((~port_active & ~act_r & (port_data_plus_oe | port_data_minus_oe)) == '0)
      else $error("data pin driven on unselected port");
   a_rx_gated: assert property ((core_rx_dp & ~port_active) == '0)
      else $error("data sampled on unselected port");
   a_oc_gated: assert property ((core_overcurrent & ~port_active) == '0)
      else $error("over-current seen on unselected port");
   a_conn_gated: assert property ((core_conn_change_out & ~port_active) == '0)
      else $error("connect change from unselected port");
   a_desc_answer: assert property (desc_rd |=> desc_valid)
      else $error("descriptor read not answered");
   a_desc_count: assert property (desc_rd && desc_idx == 4'h2 |=> desc_byte == cnt_r)
      else $error("port count byte wrong");
   a_desc_head: assert property (desc_rd && desc_idx == 4'h0 |=> desc_byte == `UHPS_DESC_LEN)
      else $error("length byte wrong");
   a_req_check: assert property (req_valid |=> req_done && req_error == (port_r == 8'h00 || port_r > cnt_r))
      else $error("port request answer wrong");
   c_count_read: cover property (desc_rd && desc_idx == 4'h2);
   c_req_error: cover property (req_valid ##1 req_error);
   c_one_port: cover property (port_active == 1);
endmodule
bind uhps_top uhps_top_sva #(.NPORTS(NPORTS)) uhps_top_sva_i (.aclk, .aresetn, .port_active, .port_power_enable_n,
   .port_data_plus_oe, .port_data_minus_oe, .core_rx_dp, .core_overcurrent, .core_conn_change_out, .desc_rd,
   .desc_idx, .desc_byte, .desc_valid, .req_valid, .req_port, .req_done, .req_error);

// File: tb/uhps_host_model.sv
module uhps_host_model (
   input wire aclk,
   input wire start,
   input wire slow,
   input wire [7:0] desc_byte,
   input wire desc_valid,
   output reg desc_rd,
   output reg [3:0] desc_idx,
   output reg [71:0] img,
   output reg busy
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [3:0] sent_r;
   reg [3:0] got_r;
   wire go = busy && sent_r < 4'h9 && !(slow && desc_rd);
   initial begin
      {desc_rd, desc_idx, img, busy, sent_r, got_r} = '0;
   end
   // ****************************************
   // host fetch of the nine descriptor bytes, gapped when slow
   // ****************************************
   always @(posedge aclk) begin
      if (start && !busy) begin
         busy <= 1'b1;
         sent_r <= 4'h0;
         got_r <= 4'h0;
      end else if (busy) begin
         desc_rd <= go;
         desc_idx <= sent_r;
         if (go) sent_r <= sent_r + 4'h1;
         if (desc_valid) begin
            img[got_r*8 +: 8] <= desc_byte;
            got_r <= got_r + 4'h1;
            busy <= got_r != 4'h8;
         end
      end
   end
endmodule

// File: tb/tb_top.sv
`include "uhps_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [7:0] awaddr = 8'h00;
   reg [7:0] araddr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg [3:0] wstrb = 4'hF;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   reg por = 1'b0, strap_a = 1'b0, strap_b_n = 1'b1, req_valid = 1'b0, start = 1'b0, slow = 1'b0;
   reg [3:0] oc_n = 4'hF, dp_i = 4'h0, dm_i = 4'h0, pwr_on = 4'h0, tx_dp = 4'h0, tx_dm = 4'h0, tx_oe = 4'h0, chg = 4'h0;
   reg [7:0] req_port = 8'h00;
   wire awready, wready, bvalid, arready, rvalid, desc_rd, desc_valid, req_done, req_error, busy;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [3:0] pen_n, dp_o, dm_o, dp_oe, dm_oe, rx_dp, rx_dm, oc, chg_out, active, desc_idx;
   wire [7:0] desc_byte;
   wire [71:0] img;
   integer fail_count = 0, compares = 0;
   // free running clock
   always #2.5 aclk = ~aclk;
   uhps_top uhps_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hub_power_on_reset(por),
      .port_count_strap_a(strap_a), .port_count_strap_b_n(strap_b_n), .port_overcurrent_sense_n(oc_n),
      .port_power_enable_n(pen_n), .port_data_plus_i(dp_i), .port_data_minus_i(dm_i), .port_data_plus_o(dp_o),
      .port_data_minus_o(dm_o), .port_data_plus_oe(dp_oe), .port_data_minus_oe(dm_oe), .core_power_on(pwr_on),
      .core_tx_dp(tx_dp), .core_tx_dm(tx_dm), .core_tx_oe(tx_oe), .core_rx_dp(rx_dp), .core_rx_dm(rx_dm),
      .core_overcurrent(oc), .core_conn_change(chg), .core_conn_change_out(chg_out), .desc_rd(desc_rd),
      .desc_idx(desc_idx), .desc_byte(desc_byte), .desc_valid(desc_valid), .req_valid(req_valid),
      .req_port(req_port), .req_done(req_done), .req_error(req_error), .port_active(active));
   uhps_host_model uhps_host_model_i (.aclk(aclk), .start(start), .slow(slow), .desc_byte(desc_byte),
      .desc_valid(desc_valid), .desc_rd(desc_rd), .desc_idx(desc_idx), .img(img), .busy(busy));
   // ****************************************
   // checking and bus tasks
   // ****************************************
   task summarize;
      begin
         $display("compares %0d fail_count %0d", compares, fail_count);
         if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input string what, input [39:0] exp, input [39:0] got);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task axw(input [7:0] a, input [31:0] d, output [1:0] r);
      integer n;
      reg ta, tw, tb;
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         {awvalid, wvalid, bready} <= 3'h7;
         tb = 1'b0;
         for (n = 0; n < 40 && !tb; n = n + 1) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
         end
         if (!tb) begin
            chk("write wait", 1, 0);
            summarize;
         end
      end
   endtask
   task axr(input [7:0] a, output [31:0] d, output [1:0] r);
      integer n;
      reg ta, tr;
      begin
         @(posedge aclk);
         araddr <= a;
         {arvalid, rready} <= 2'h3;
         tr = 1'b0;
         for (n = 0; n < 40 && !tr; n = n + 1) begin
            @(negedge aclk);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
         end
         if (!tr) begin
            chk("read wait", 1, 0);
            summarize;
         end
      end
   endtask
   task fetch(input s);
      integer n;
      begin
         @(posedge aclk);
         slow <= s;
         start <= 1'b1;
         @(posedge aclk);
         start <= 1'b0;
         // let busy rise before waiting on its fall
         @(negedge aclk);
         for (n = 0; n < 80 && busy !== 1'b0; n = n + 1) @(negedge aclk);
         if (busy !== 1'b0) begin
            chk("fetch wait", 1, 0);
            summarize;
         end
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task s_strap;
      integer c;
      begin
         for (c = 0; c < 4; c = c + 1) begin
            @(posedge aclk);
            {strap_a, strap_b_n, por} <= {c[0], ~c[1], 1'b1};
            repeat (6) @(posedge aclk);
            por <= 1'b0;
            repeat (4) @(posedge aclk);
            {strap_a, strap_b_n} <= {~c[0], c[1]};
            repeat (4) @(posedge aclk);
            chk("strap active", (1 << (c + 1)) - 1, active);
            fetch(1'b0);
            chk("strap count", c + 1, img[23:16]);
         end
      end
   endtask
   task s_reg;
      reg [31:0] d;
      reg [1:0] r;
      integer k;
      begin
         axr(`UHPS_OFS_CHAR, d, r);
         chk("char reset", `UHPS_CHAR_RST, d);
         axw(`UHPS_OFS_REMOVE, 32'h14, r);
         axw(`UHPS_OFS_PWRMASK, 32'h1E, r);
         axw(`UHPS_OFS_CTRL, 32'h3, r);
         chk("ctrl resp", `UHPS_RESP_OKAY, r);
         axr(`UHPS_OFS_CTRL, d, r);
         chk("ctrl read", 32'h3, d);
         // write without byte lane 0 leaves the bitmap alone
         wstrb <= 4'hE;
         axw(`UHPS_OFS_REMOVE, 32'h1E, r);
         wstrb <= 4'hF;
         axr(`UHPS_OFS_REMOVE, d, r);
         chk("removable lane", 32'h14, d);
         axw(8'h20, 32'h1, r);
         chk("unmapped write", `UHPS_RESP_SLVERR, r);
         axr(8'h24, d, r);
         chk("unmapped read", {`UHPS_RESP_SLVERR, 32'h0}, {r, d});
         repeat (2) @(posedge aclk);
         chk("reg active", 4'h3, active);
         axr(`UHPS_OFS_STATUS, d, r);
         chk("status", 32'h0000_2032, d);
         fetch(1'b1);
         chk("length", `UHPS_DESC_LEN, img[7:0]);
         chk("type", `UHPS_DESC_TYPE, img[15:8]);
         chk("count", 8'h02, img[23:16]);
         chk("char high", 8'h00, img[39:32]);
         chk("power good", 8'h32, img[47:40]);
         chk("current", 8'h64, img[55:48]);
         chk("removable", 8'h04, img[63:56]);
         chk("power mask", 8'h06, img[71:64]);
         // every switching, compound and over-current code
         for (k = 0; k < 4; k = k + 1) begin
            axw(`UHPS_OFS_CHAR, 32'h00643200 | k | (k << 3) | ((k & 1) << 2), r);
            fetch(1'b0);
            chk("char low", k | (k << 3) | ((k & 1) << 2), img[31:24]);
         end
      end
   endtask
   task s_pins;
      begin
         @(posedge aclk);
         {oc_n, pwr_on, tx_oe, tx_dp, tx_dm, dp_i, dm_i, chg} <= {4'h0, 4'h0, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
         repeat (4) @(posedge aclk);
         @(negedge aclk);
         chk("power enable", 4'h3, pen_n);
         chk("data oe", 4'h3, dp_oe);
         chk("data out", 4'h3, dp_o);
         chk("data in", 4'h3, rx_dp);
         chk("minus pins", {4'h3, 4'h3, 4'h3}, {dm_o, dm_oe, rx_dm});
         chk("over-current", 4'h3, oc);
         chk("conn change", 4'h1, chg_out);
         // masked ports are powered one by one, never ganged
         @(posedge aclk);
         pwr_on <= 4'h1;
         repeat (2) @(posedge aclk);
         @(negedge aclk);
         chk("port power", 4'h2, pen_n);
      end
   endtask
   task s_req;
      integer i;
      reg [7:0] p;
      begin
         for (i = 0; i < 5; i = i + 1) begin
            p = (i == 4) ? 8'h05 : i[7:0];
            @(posedge aclk);
            {req_valid, req_port} <= {1'b1, p};
            @(posedge aclk);
            req_valid <= 1'b0;
            @(negedge aclk);
            chk("req done", 1, req_done);
            chk("req error", p == 8'h00 || p > 8'h02, req_error);
         end
      end
   endtask
   // reset, then the scenarios in turn
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      s_strap;
      s_reg;
      s_pins;
      s_req;
      summarize;
   end
endmodule
